// ==== logic/vdsp_dispatch.sv ====
// Sequencer for the vector_dispatch_instruction of the processor.
`timescale 1ns/1ns
// Behaviour
// - Mask bit per peripheral fixed, not remappable.
// - Shared mask bit disables its peripherals together.
// - Second word: bit15 stack change, rest base.
// - Vector entry: bit15 clear direct, bits 0-14 address.
// - Acknowledge, add code to base, fetch entry.
// - Direct zero: jump at once, nothing else.
// - Stack change: load words 6,7; push old.
// - Table word one push bit/handler; two mask.
// - Push bit set: push return block.
// - Accumulator two gets table address, bit15 clear.
// - Push mask; OR mask to accumulator zero, word5.
// - Mask out with the new mask, interrupts on.
// - Finally jump to table handler address.
// - Mode from direct, stack change, push bits.
// - Direct mode ignores other bits, no table.
// - Acknowledge returns nearest requester code, low bits.
module vdsp_dispatch (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic start_i,
	input wire logic [15:0] instr_word_i,
	input wire vdsp_pkg::vdsp_acs_t acs_i,
	output vdsp_pkg::vdsp_mem_t mem_o,
	input wire logic [15:0] mem_rdata_i,
	input wire logic mem_ack_i,
	output logic interrupt_acknowledge_op_req_o,
	input wire logic interrupt_acknowledge_op_ack_i,
	input wire logic [15:0] interrupt_acknowledge_op_code_i,
	output logic mask_out_op_req_o,
	output logic [15:0] mask_out_op_mask_o,
	output logic mask_out_op_int_on_o,
	input wire logic mask_out_op_ack_i,
	output logic [14:0] pc_o,
	output logic pc_load_o,
	output logic [15:0] ac0_o,
	output logic ac0_load_o,
	output logic [15:0] ac2_o,
	output logic ac2_load_o,
	output logic busy_o,
	output logic done_o
);
	import vdsp_pkg::*;

	// ****************************************************************
	// State record.
	// ****************************************************************
	typedef struct packed {
		vdsp_st_t st;
		logic sc;
		logic [AW-1:0] vt;
		logic [AW-1:0] device_control_table;
		logic [3:0] idx;
		logic [3:0] nwr;
		logic [NRD-1:0][15:0] rb;
		logic [QD-1:0][AW-1:0] wa;
		logic [QD-1:0][15:0] wd;
		vdsp_mem_t mem;
		logic interrupt_acknowledge_op_req;
		logic mask_out_op_req;
		logic [15:0] mask;
		logic [14:0] pc;
		logic pc_load;
		logic [15:0] ac0;
		logic ac0_load;
		logic [15:0] ac2;
		logic ac2_load;
		logic busy;
		logic done;
	} vdsp_state_t;

	vdsp_state_t s_q;
	vdsp_state_t s_d;

	// Address of each read slot, the two table words included.
	function automatic logic [AW-1:0] rd_loc(input logic [3:0] i,
		input logic [AW-1:0] device_control_table);
		logic [AW-1:0] a;
		a = LOC_RET;
		if (i == R_DCT0)
			a = device_control_table;
		else if (i == R_DCT1)
			a = device_control_table + 15'h0001;
		else if (i == R_MASK)
			a = LOC_MASK;
		else if (i == R_N6)
			a = LOC_NEW_LIM;
		else if (i == R_N7)
			a = LOC_NEW_FLT;
		else if (i != R_LOC0)
			a = LOC_SP + {11'h000, i - R_SP};
		return a;
	endfunction : rd_loc

	// ****************************************************************
	// Next state.
	// ****************************************************************
	// All reads finish before any write so a refused or stalled
	// memory never leaves a half-built stack behind.
	always_comb
	begin
		logic [AW-1:0] sp;
		logic [3:0] n;
		logic [15:0] nm;
		sp = '0;
		n = '0;
		nm = '0;
		s_d = s_q;
		s_d.pc_load = 1'b0;
		s_d.ac0_load = 1'b0;
		s_d.ac2_load = 1'b0;
		s_d.done = 1'b0;
		unique case (s_q.st)
			S_IDLE:
			begin
				if (start_i)
				begin
					s_d.sc = instr_word_i[FLAG_BIT];
					s_d.vt = instr_word_i[AW-1:0];
					s_d.interrupt_acknowledge_op_req = 1'b1;
					s_d.st = S_INTERRUPT_ACKNOWLEDGE_OP;
				end
			end
			S_INTERRUPT_ACKNOWLEDGE_OP:
			begin
				if (interrupt_acknowledge_op_ack_i)
				begin
					s_d.interrupt_acknowledge_op_req = 1'b0;
					s_d.mem.req = 1'b1;
					s_d.mem.we = 1'b0;
					// Only the code field counts; the sum wraps.
					s_d.mem.addr = s_q.vt
						+ {9'h000, interrupt_acknowledge_op_code_i[CODE_W-1:0]};
					s_d.st = S_VEC;
				end
			end
			S_VEC:
			begin
				if (mem_ack_i)
				begin
					s_d.device_control_table = mem_rdata_i[AW-1:0];
					if (!mem_rdata_i[FLAG_BIT])
					begin
						s_d.mem.req = 1'b0;
						s_d.pc = mem_rdata_i[AW-1:0];
						s_d.pc_load = 1'b1;
						s_d.done = 1'b1;
						s_d.st = S_IDLE;
					end
					else
					begin
						s_d.idx = R_DCT0;
						s_d.mem.addr = mem_rdata_i[AW-1:0];
						s_d.st = S_RD;
					end
				end
			end
			S_RD:
			begin
				if (mem_ack_i)
				begin
					s_d.rb[s_q.idx] = mem_rdata_i;
					if (s_q.idx == R_LOC0)
					begin
						s_d.mem.req = 1'b0;
						s_d.st = S_BUILD;
					end
					else
					begin
						s_d.idx = s_q.idx + 4'h1;
						s_d.mem.addr = rd_loc(s_q.idx + 4'h1, s_q.device_control_table);
					end
				end
			end
			S_BUILD:
			begin
				sp = s_q.rb[R_SP][AW-1:0];
				if (s_q.sc)
				begin
					s_d.wa[n] = LOC_LIM;
					s_d.wd[n] = s_q.rb[R_N6];
					n = n + 4'h1;
					s_d.wa[n] = LOC_FLT;
					s_d.wd[n] = s_q.rb[R_N7];
					n = n + 4'h1;
					for (int k = 0; k < STK_WORDS; k++)
					begin
						sp = sp + 15'h0001;
						s_d.wa[n] = sp;
						s_d.wd[n] = s_q.rb[R_SP + k[3:0]];
						n = n + 4'h1;
					end
				end
				if (s_q.rb[R_DCT0][FLAG_BIT])
				begin
					for (int k = 0; k < 5; k++)
					begin
						sp = sp + 15'h0001;
						s_d.wa[n] = sp;
						n = n + 4'h1;
					end
					s_d.wd[n - 4'h5] = acs_i.ac0;
					s_d.wd[n - 4'h4] = acs_i.ac1;
					s_d.wd[n - 4'h3] = acs_i.ac2;
					s_d.wd[n - 4'h2] = acs_i.ac3;
					s_d.wd[n - 4'h1] = {acs_i.carry,
						s_q.rb[R_LOC0][AW-1:0]};
				end
				sp = sp + 15'h0001;
				s_d.wa[n] = sp;
				s_d.wd[n] = s_q.rb[R_MASK];
				n = n + 4'h1;
				s_d.wa[n] = LOC_SP;
				s_d.wd[n] = {1'b0, sp};
				n = n + 4'h1;
				nm = s_q.rb[R_DCT1] | s_q.rb[R_MASK];
				s_d.mask = nm;
				s_d.wa[n] = LOC_MASK;
				s_d.wd[n] = nm;
				s_d.nwr = n;
				s_d.idx = '0;
				s_d.mem.req = 1'b1;
				s_d.mem.we = 1'b1;
				s_d.mem.addr = s_d.wa[0];
				s_d.mem.wdata = s_d.wd[0];
				s_d.st = S_WR;
			end
			S_WR:
			begin
				if (mem_ack_i)
				begin
					if (s_q.idx == s_q.nwr)
					begin
						s_d.mem.req = 1'b0;
						s_d.mem.we = 1'b0;
						s_d.ac2 = {1'b0, s_q.device_control_table};
						s_d.ac2_load = 1'b1;
						s_d.ac0 = s_q.mask;
						s_d.ac0_load = 1'b1;
						s_d.mask_out_op_req = 1'b1;
						s_d.st = S_MASK_OUT_OP;
					end
					else
					begin
						s_d.idx = s_q.idx + 4'h1;
						s_d.mem.addr = s_q.wa[s_q.idx + 4'h1];
						s_d.mem.wdata = s_q.wd[s_q.idx + 4'h1];
					end
				end
			end
			S_MASK_OUT_OP:
			begin
				if (mask_out_op_ack_i)
				begin
					s_d.mask_out_op_req = 1'b0;
					s_d.pc = s_q.rb[R_DCT0][AW-1:0];
					s_d.pc_load = 1'b1;
					s_d.done = 1'b1;
					s_d.st = S_IDLE;
				end
			end
			default:
				s_d.st = S_IDLE;
		endcase
		// Busy is registered so the output comes straight from a flop.
		s_d.busy = (s_d.st != S_IDLE);
		if (sys_rst_i)
			s_d = '0;
	end

	// ****************************************************************
	// Registers and outputs.
	// ****************************************************************
	always_ff @(posedge sys_clk_i)
	begin
		s_q <= s_d;
	end

	assign mem_o = s_q.mem;
	assign interrupt_acknowledge_op_req_o = s_q.interrupt_acknowledge_op_req;
	assign mask_out_op_req_o = s_q.mask_out_op_req;
	// Bit positions map straight to peripherals; no remap exists.
	assign mask_out_op_mask_o = s_q.ac0;
	assign mask_out_op_int_on_o = s_q.mask_out_op_req;
	assign pc_o = s_q.pc;
	assign pc_load_o = s_q.pc_load;
	assign ac0_o = s_q.ac0;
	assign ac0_load_o = s_q.ac0_load;
	assign ac2_o = s_q.ac2;
	assign ac2_load_o = s_q.ac2_load;
	assign busy_o = s_q.busy;
	assign done_o = s_q.done;

	// ****************************************************************
	// Checks.
	// ****************************************************************
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	interrupt_acknowledge_op_first_a: assert property ((s_q.st == S_IDLE) && start_i |=>
		interrupt_acknowledge_op_req_o && !mem_o.req)
		else $error("acknowledge not issued first");
	vec_addr_a: assert property ((s_q.st == S_INTERRUPT_ACKNOWLEDGE_OP) && interrupt_acknowledge_op_ack_i |=>
		mem_o.addr == $past(s_q.vt + {9'h000, interrupt_acknowledge_op_code_i[5:0]}))
		else $error("vector entry address wrong");
	mode_a_jump_a: assert property ((s_q.st == S_VEC) && mem_ack_i
		&& !mem_rdata_i[15] |=> pc_load_o && done_o
		&& pc_o == $past(mem_rdata_i[14:0]))
		else $error("direct jump wrong");
	mode_a_quiet_a: assert property ((s_q.st == S_VEC) && mem_ack_i
		&& !mem_rdata_i[15] |=> !mem_o.req [*2])
		else $error("direct mode touched memory");
	read_no_write_a: assert property ((s_q.st == S_RD) |-> !mem_o.we
		&& !ac0_load_o && !ac2_load_o)
		else $error("state changed during reads");
	mask_out_op_on_a: assert property ($rose(mask_out_op_req_o) |-> mask_out_op_int_on_o
		&& mask_out_op_mask_o == ac0_o && ac0_load_o)
		else $error("mask out without enable");
	ac2_build_a: assert property (ac2_load_o |-> !ac2_o[15]
		&& ac2_o[14:0] == s_q.device_control_table)
		else $error("accumulator two wrong");
	mask_or_a: assert property (ac0_load_o |-> ac0_o ==
		(s_q.rb[R_DCT1] | s_q.rb[R_MASK]))
		else $error("new mask wrong");
	final_pc_a: assert property ((s_q.st == S_MASK_OUT_OP) && mask_out_op_ack_i |=>
		pc_load_o && pc_o == s_q.rb[R_DCT0][14:0] && !mask_out_op_req_o)
		else $error("handler jump wrong");
endmodule : vdsp_dispatch

// ==== logic/vdsp_pkg.sv ====
// Constants and carrier types for the vectored interrupt dispatch sequencer.
package vdsp_pkg;
	// ****************************************************************
	// Word layout: bit 15 is each word's flag, bits 14..0 an address.
	// ****************************************************************
	localparam int AW = 15;
	localparam int FLAG_BIT = 15;
	localparam int CODE_W = 6;
	localparam int VT_ENTRIES = 64;
	// ****************************************************************
	// Fixed memory locations.
	// ****************************************************************
	localparam logic [AW-1:0] LOC_RET = 15'h0000;
	localparam logic [AW-1:0] LOC_MASK = 15'h0005;
	localparam logic [AW-1:0] LOC_NEW_LIM = 15'h0006;
	localparam logic [AW-1:0] LOC_NEW_FLT = 15'h0007;
	localparam logic [AW-1:0] LOC_SP = 15'h0020;
	localparam logic [AW-1:0] LOC_FP = 15'h0021;
	localparam logic [AW-1:0] LOC_LIM = 15'h0022;
	localparam logic [AW-1:0] LOC_FLT = 15'h0023;
	// ****************************************************************
	// Read list slots, write queue depth.
	// ****************************************************************
	localparam logic [3:0] R_DCT0 = 4'h0;
	localparam logic [3:0] R_DCT1 = 4'h1;
	localparam logic [3:0] R_MASK = 4'h2;
	localparam logic [3:0] R_SP = 4'h3;
	localparam logic [3:0] R_N6 = 4'h7;
	localparam logic [3:0] R_N7 = 4'h8;
	localparam logic [3:0] R_LOC0 = 4'h9;
	localparam int NRD = 10;
	localparam int QD = 14;
	localparam logic [3:0] STK_WORDS = 4'h4;
	typedef enum logic [2:0] {
		S_IDLE = 3'h0, S_INTERRUPT_ACKNOWLEDGE_OP = 3'h1, S_VEC = 3'h3, S_RD = 3'h2,
		S_BUILD = 3'h6, S_WR = 3'h7, S_MASK_OUT_OP = 3'h5
	} vdsp_st_t;
	typedef struct packed {
		logic req;
		logic we;
		logic [AW-1:0] addr;
		logic [15:0] wdata;
	} vdsp_mem_t;
	typedef struct packed {
		logic [15:0] ac0;
		logic [15:0] ac1;
		logic [15:0] ac2;
		logic [15:0] ac3;
		logic carry;
	} vdsp_acs_t;
endpackage : vdsp_pkg

// ==== testbench/vdsp_far_side.sv ====
// Memory and peripheral controllers facing the dispatch sequencer.
`timescale 1ns/1ns
module vdsp_far_side
	import vdsp_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic slow_i,
	input wire logic [5:0] code_i,
	input wire vdsp_pkg::vdsp_mem_t mem_i,
	output logic [15:0] rdata_o,
	output logic mem_ack_o,
	input wire logic interrupt_acknowledge_op_req_i,
	output logic interrupt_acknowledge_op_ack_o,
	output logic [15:0] interrupt_acknowledge_op_code_o,
	input wire logic mask_out_op_req_i,
	input wire logic [15:0] mask_out_op_mask_i,
	output logic mask_out_op_ack_o,
	output logic [3:0] dis_o
);
	logic [15:0] mem [0:32767];
	logic tick_q;
	// Wired mask bit of each peripheral; 1 and 2 share one bit.
	localparam logic [3:0][3:0] MAPB = {4'h9, 4'h3, 4'h3, 4'h0};
	// Released read data shows the inverse and released code lines all ones, so stale values cannot pass.
	assign rdata_o = mem_ack_o ? mem[mem_i.addr] : ~mem[mem_i.addr];
	assign interrupt_acknowledge_op_code_o = interrupt_acknowledge_op_ack_o ? {10'h000, code_i} : 16'hffff;
	// Answers every other cycle when slow, as a busy memory would.
	always @(posedge sys_clk_i)
	begin
		tick_q <= sys_rst_i ? 1'b0 : ~tick_q;
		mem_ack_o <= !sys_rst_i && mem_i.req && !mem_ack_o && (!slow_i || tick_q);
		interrupt_acknowledge_op_ack_o <= !sys_rst_i && interrupt_acknowledge_op_req_i && !interrupt_acknowledge_op_ack_o
			&& (!slow_i || tick_q);
		mask_out_op_ack_o <= !sys_rst_i && mask_out_op_req_i && !mask_out_op_ack_o;
		if (mem_i.req && mem_ack_o && mem_i.we)
			mem[mem_i.addr] <= mem_i.wdata;
		if (sys_rst_i)
			dis_o <= 4'h0;
		else if (mask_out_op_req_i && mask_out_op_ack_o)
			for (int k = 0; k < 4; k++)
				dis_o[k] <= mask_out_op_mask_i[MAPB[k]];
	end
endmodule : vdsp_far_side

// ==== testbench/tb_top.sv ====
// Self-checking bench for the vectored interrupt dispatch sequencer.
`timescale 1ns/1ns
module tb_top;
	import vdsp_pkg::*;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic start_i = 1'b0;
	logic slow = 1'b0;
	logic [15:0] instr = 16'h0000;
	logic [5:0] code = 6'h00;
	vdsp_acs_t acs = '0;
	vdsp_mem_t mem;
	logic [15:0] rdata, interrupt_acknowledge_op_code, mask_out_op_mask, ac0, ac2, mk_s, ac0_s, ac2_s;
	logic ack, interrupt_acknowledge_op_req, interrupt_acknowledge_op_ack, mask_out_op_req, int_on, mask_out_op_ack, io_s;
	logic pc_load, ac0_load, ac2_load, busy, done;
	logic [14:0] pc, pc_s;
	logic [3:0] dis;
	logic [15:0] lfsr = 16'hd61a;
	logic [31:0] wq [$];
	int fail_count = 0;
	int total_checks = 0;
	int dones = 0;
	int mask_out_op_n = 0;
	int late = 0;
	int cyc = 0;
	always #5 sys_clk_i = ~sys_clk_i;
	vdsp_dispatch dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
		.start_i(start_i), .instr_word_i(instr), .acs_i(acs), .mem_o(mem),
		.mem_rdata_i(rdata), .mem_ack_i(ack), .interrupt_acknowledge_op_req_o(interrupt_acknowledge_op_req),
		.interrupt_acknowledge_op_ack_i(interrupt_acknowledge_op_ack), .interrupt_acknowledge_op_code_i(interrupt_acknowledge_op_code), .mask_out_op_req_o(mask_out_op_req),
		.mask_out_op_mask_o(mask_out_op_mask), .mask_out_op_int_on_o(int_on), .mask_out_op_ack_i(mask_out_op_ack),
		.pc_o(pc), .pc_load_o(pc_load), .ac0_o(ac0), .ac0_load_o(ac0_load),
		.ac2_o(ac2), .ac2_load_o(ac2_load), .busy_o(busy), .done_o(done));
	vdsp_far_side fs_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
		.slow_i(slow), .code_i(code), .mem_i(mem), .rdata_o(rdata),
		.mem_ack_o(ack), .interrupt_acknowledge_op_req_i(interrupt_acknowledge_op_req), .interrupt_acknowledge_op_ack_o(interrupt_acknowledge_op_ack),
		.interrupt_acknowledge_op_code_o(interrupt_acknowledge_op_code), .mask_out_op_req_i(mask_out_op_req),
		.mask_out_op_mask_i(mask_out_op_mask), .mask_out_op_ack_o(mask_out_op_ack), .dis_o(dis));
	// Pulsed results are caught in the cycle they stand.
	always @(posedge sys_clk_i)
	begin
		cyc++;
		if (mem.req && ack && mem.we)
			wq.push_back({1'b0, mem.addr, mem.wdata});
		if (mem.req && ack && !mem.we && wq.size() > 0)
			late++;
		if (pc_load)
			pc_s <= pc;
		if (ac0_load)
			ac0_s <= ac0;
		if (ac2_load)
			ac2_s <= ac2;
		if (mask_out_op_req && mask_out_op_ack)
		begin
			mk_s <= mask_out_op_mask;
			io_s <= int_on;
			mask_out_op_n++;
		end
		if (done)
			dones++;
		if (cyc == 20000)
		begin
			fail_count++;
			report_and_stop();
		end
	end
	function logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction : rnd
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// One dispatch in the given mode, against a model built from queues.
	task automatic run(input int mode);
		logic [15:0] r, sp, old5, w6, w7, l0, d1, nm;
		logic [15:0] s [4];
		logic [15:0] v [5];
		logic [14:0] base, device_control_table, hnd, ea;
		logic sc, pb;
		logic [31:0] exp [$];
		int d0, m0;
		@(posedge sys_clk_i);
		#1;
		r = rnd();
		base = {2'b10, r[12:0]};
		code = r[15:10];
		sc = r[14];
		if (mode == 0)
		begin
			base = 15'h7fd0; // The index sum wraps past the top.
			code = {3'b111, r[2:0]};
		end
		else
			sc = (mode > 2);
		pb = (mode == 2) || (mode == 4);
		r = rnd();
		device_control_table = {3'b010, r[11:0]};
		r = rnd();
		hnd = r[14:0];
		ea = base + {9'h000, code};
		fs_u.mem[ea] = (mode == 0) ? {1'b0, hnd} : {1'b1, device_control_table};
		fs_u.mem[device_control_table] = {pb, hnd};
		d1 = rnd();
		old5 = rnd();
		w6 = rnd();
		w7 = rnd();
		l0 = rnd();
		r = rnd();
		sp = {8'h01, r[7:0]};
		s[0] = sp;
		for (int k = 1; k < 4; k++)
			s[k] = rnd();
		fs_u.mem[device_control_table + 15'h0001] = d1;
		fs_u.mem[5] = old5;
		fs_u.mem[6] = w6;
		fs_u.mem[7] = w7;
		fs_u.mem[0] = l0;
		for (int k = 0; k < 4; k++)
			fs_u.mem[32 + k] = s[k];
		acs = {rnd(), rnd(), rnd(), rnd(), r[8]};
		v = '{acs.ac0, acs.ac1, acs.ac2, acs.ac3, {acs.carry, l0[14:0]}};
		nm = d1 | old5;
		exp = {};
		if (mode != 0)
		begin
			if (sc)
			begin
				exp.push_back({1'b0, 15'h0022, w6});
				exp.push_back({1'b0, 15'h0023, w7});
				for (int k = 0; k < 4; k++)
				begin
					sp++;
					exp.push_back({1'b0, sp[14:0], s[k]});
				end
			end
			for (int k = 0; k < 5 && pb; k++)
			begin
				sp++;
				exp.push_back({1'b0, sp[14:0], v[k]});
			end
			sp++;
			exp.push_back({1'b0, sp[14:0], old5});
			exp.push_back({1'b0, 15'h0020, sp});
			exp.push_back({1'b0, 15'h0005, nm});
		end
		wq = {};
		late = 0;
		d0 = dones;
		m0 = mask_out_op_n;
		instr = {sc, base};
		start_i = 1'b1;
		@(posedge sys_clk_i);
		#1;
		start_i = 1'b0;
		@(posedge sys_clk_i);
		#1;
		start_i = 1'b1; // A second start while busy must be dropped.
		@(posedge sys_clk_i);
		#1;
		start_i = 1'b0;
		for (int k = 0; k < 300 && dones == d0; k++)
			@(posedge sys_clk_i);
		repeat (8) @(posedge sys_clk_i);
		#1;
		check("done count", dones, d0 + 1);
		check("busy", busy, 0);
		check("pc", pc_s, hnd);
		check("write count", wq.size(), exp.size());
		for (int k = 0; k < exp.size() && k < wq.size(); k++)
			check("write", wq[k], exp[k]);
		check("late reads", late, 0);
		check("mask outs", mask_out_op_n, m0 + (mode != 0));
		if (mode != 0)
		begin
			check("ac0", ac0_s, nm);
			check("ac2", ac2_s, {1'b0, device_control_table});
			check("mask out", {mk_s, 15'h0, io_s}, {nm, 16'h0001});
			check("disable", dis, {nm[9], nm[3], nm[3], nm[0]});
		end
		$display("test mode %0d finished", mode);
	endtask : run
	task report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	// Reset, then every mode at both memory speeds.
	initial
	begin
		repeat (4) @(posedge sys_clk_i);
		#1;
		sys_rst_i = 1'b0;
		check("idle", {busy, done, mem.req, interrupt_acknowledge_op_req, mask_out_op_req}, 0);
		for (int lap = 0; lap < 4; lap++)
		begin
			slow = lap[0];
			for (int m = 0; m < 5; m++)
				run(m);
		end
		report_and_stop();
	end
endmodule : tb_top
